//--- dv/mfpc_board_model.sv
// mfpc_board_model: board side of the three multifunction pads
// assumes one pad per bit; a weak pull-down holds a pad that nobody drives
`default_nettype none
module mfpc_board_model
(
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext_en,
   input wire logic [2:0] ext_level,
   output logic [2:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // device drive wins; contention is a board fault and is not modelled
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] & ext_level[i]);
      end
   end
endmodule
`default_nettype wire

//--- dv/mfpc_top_bench.sv
// mfpc_top_bench: register and pad tests of the multifunction pin block
// assumes the design carries its own assertions and the board model resolves pads
`default_nettype none
module mfpc_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import mfpc_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   mfpc_req_s req = '0;
   mfpc_src_s src = '0;
   mfpc_cfg_s cfg_a, cfg_b, cfg_c;
   logic [7:0] rdata;
   logic rvalid;
   logic [2:0] pin_in, pin_out, pin_oe, pin_ie, pin_mux;
   logic [2:0] ext_en = 3'h0;
   logic [2:0] ext_level = 3'h0;
   logic [4:0] codes [17] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
      5'h0C, 5'h0D, 5'h10, 5'h11, 5'h12, 5'h15, 5'h1B, 5'h1C, 5'h1D};
   logic [7:0] a;
   int err_total = 0;
   int tests_run = 0;
   always #4 clk_sys = ~clk_sys;
   mfpc_top mfpc_top_inst (.clk_sys(clk_sys), .resetn(resetn), .req(req),
      .req_valid(req_valid), .serial_dout_pin_config(cfg_a), .irq_pin_config(cfg_b),
      .second_bitclock_pin_config(cfg_c), .rdata(rdata), .rvalid(rvalid), .src(src),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ie(pin_ie),
      .pin_to_input_mux(pin_mux));
   mfpc_board_model mfpc_board_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_level(ext_level), .pin_in(pin_in));
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic access(input logic wr, input logic [7:0] bk, pg, ad, wd);
      req = '{wr: wr, book: bk, page: pg, addr: ad, wdata: wd};
      req_valid = 1'b1;
      step(1);
      req_valid = 1'b0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
      access(1'b1, MFPC_BOOK, MFPC_PAGE, ad, wd);
      step(1);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      access(1'b0, MFPC_BOOK, MFPC_PAGE, ad, 8'h00);
      chk({7'h00, rvalid}, 8'h01, "read strobe");
      chk(rdata, exp, "read data");
      step(1);
   endtask
   // one-hot source for a selector; the static level code needs none
   function automatic mfpc_src_s pick(input logic [4:0] code);
      mfpc_src_s s;
      s = '0;
      case (code)
         5'h04: s.shared_bitbang_level = 1'b1;
         5'h05: s.pdm_clock = 1'b1;
         5'h06: s.general_clock_output = 1'b1;
         5'h07: s.interrupt_line = 4'h1;
         5'h08: s.interrupt_line = 4'h2;
         5'h09: s.interrupt_line = 4'h4;
         5'h0A: s.interrupt_line = 4'h8;
         5'h0C, 5'h11: s.port_one_word_clock_out = 1'b1;
         5'h0D: s.port_one_bit_clock_out = 1'b1;
         5'h10: s.port_one_data_out = 1'b1;
         5'h12: s.port_two_bit_clock_out = 1'b1;
         5'h15: s.port_two_data_out = 1'b1;
         5'h1B: s.aux_port_word_clock_out = 1'b1;
         5'h1C: s.aux_port_bit_clock_out = 1'b1;
         5'h1D: s.aux_port_data_out = 1'b1;
         default: s = '0;
      endcase
      return s;
   endfunction
   task automatic give_verdict();
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_total++;
      give_verdict();
   end
   initial
   begin
      step(2);
      resetn = 1'b1;
      step(1);
      chk(cfg_a, MFPC_RST_DOUT, "cfg a");
      chk(cfg_b, MFPC_RST_IRQ, "cfg b");
      chk(cfg_c, MFPC_RST_BCLK2, "cfg c");
      chk({2'b00, pin_oe, pin_ie}, 8'h18, "reset drive");
      src = pick(5'h07) | pick(5'h10);
      step(2);
      chk({5'h00, pin_out}, 8'h03, "reset pads");
      rd(MFPC_OFS_DOUT, 8'h10);
      rd(MFPC_OFS_IRQ, 8'h07);
      rd(MFPC_OFS_BCLK2, 8'h00);
      rd(8'h42, 8'h00);
      access(1'b1, MFPC_BOOK, 8'h02, MFPC_OFS_BCLK2, 8'h55);
      step(1);
      access(1'b0, 8'h01, MFPC_PAGE, MFPC_OFS_BCLK2, 8'h00);
      chk({7'h00, rvalid}, 8'h00, "foreign read");
      step(1);
      rd(MFPC_OFS_BCLK2, 8'h00);
      for (int p = 0; p < 3; p++)
      begin
         a = MFPC_OFS_DOUT + 8'(p);
         foreach (codes[i])
         begin
            wr(a, {3'b000, codes[i]});
            src = pick(codes[i]);
            step(2);
            chk({6'h00, pin_oe[p], pin_ie[p]}, 8'h02, "drive");
            chk({7'h00, pin_out[p]}, {7'h00, codes[i] != 5'h03}, "pad");
            wr(a, {3'b111, codes[i]});
            src = ~pick(codes[i]);
            step(2);
            chk({7'h00, pin_out[p]}, {7'h00, codes[i] == 5'h03}, "pad inv");
            rd(a, {3'b111, codes[i]});
         end
         wr(a, 8'h01);
         ext_en[p] = 1'b1;
         ext_level[p] = 1'b1;
         step(4);
         chk({5'h00, pin_oe[p], pin_ie[p], pin_mux[p]}, 8'h03, "input high");
         ext_level[p] = 1'b0;
         step(4);
         chk({7'h00, pin_mux[p]}, 8'h00, "input low");
         wr(a, 8'h00);
         ext_level[p] = 1'b1;
         step(4);
         chk({5'h00, pin_oe[p], pin_ie[p], pin_mux[p]}, 8'h00, "disabled");
         ext_en[p] = 1'b0;
      end
      give_verdict();
   end
endmodule
`default_nettype wire

//--- hdl/mfpc_pin_mux.sv
// mfpc_pin_mux: selects what one multifunction pin drives from its configuration
// purely combinational; the top registers the result
`default_nettype none
module mfpc_pin_mux
   import mfpc_pkg::*;
(
   input wire mfpc_pkg::mfpc_cfg_s cfg,
   input wire mfpc_pkg::mfpc_src_s src,
   output mfpc_pkg::mfpc_drv_s drv
);
   always_comb
   begin
      drv = '0;
      // reserved codes fall to the default: pin left undriven with buffers off
      unique case (cfg.function_select)
         MFPC_FN_OFF: drv = '0;
         MFPC_FN_IN: drv.ie = 1'b1;
         MFPC_FN_LEVEL: drv = '{out: cfg.static_level, oe: 1'b1, ie: 1'b0};
         MFPC_FN_BITBANG: drv = '{out: src.shared_bitbang_level, oe: 1'b1, ie: 1'b0};
         MFPC_FN_PDMCLK: drv = '{out: src.pdm_clock, oe: 1'b1, ie: 1'b0};
         MFPC_FN_GENERAL_CLOCK_OUTPUT: drv = '{out: src.general_clock_output, oe: 1'b1, ie: 1'b0};
         MFPC_FN_INTERRUPT_LINE_ONE: drv = '{out: src.interrupt_line[0], oe: 1'b1, ie: 1'b0};
         MFPC_FN_INTERRUPT_LINE_TWO: drv = '{out: src.interrupt_line[1], oe: 1'b1, ie: 1'b0};
         MFPC_FN_INTERRUPT_LINE_THREE: drv = '{out: src.interrupt_line[2], oe: 1'b1, ie: 1'b0};
         MFPC_FN_INTERRUPT_LINE_FOUR: drv = '{out: src.interrupt_line[3], oe: 1'b1, ie: 1'b0};
         MFPC_FN_P1WCLK: drv = '{out: src.port_one_word_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_P1BCLK: drv = '{out: src.port_one_bit_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_P1DOUT: drv = '{out: src.port_one_data_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_P1WCLK2: drv = '{out: src.port_one_word_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_P2BCLK: drv = '{out: src.port_two_bit_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_P2DOUT: drv = '{out: src.port_two_data_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_AXWCLK: drv = '{out: src.aux_port_word_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_AXBCLK: drv = '{out: src.aux_port_bit_clock_out, oe: 1'b1, ie: 1'b0};
         MFPC_FN_AXDOUT: drv = '{out: src.aux_port_data_out, oe: 1'b1, ie: 1'b0};
         default: drv = '0;
      endcase
   end
endmodule
`default_nettype wire

//--- hdl/mfpc_pkg.sv
// mfpc_pkg: constants and types for the multifunction pin configuration block
// assumes a byte-wide register port with book/page/address decode outside or here
`default_nettype none
package mfpc_pkg;
   localparam logic [7:0] MFPC_BOOK = 8'h00;
   localparam logic [7:0] MFPC_PAGE = 8'h01;
   localparam logic [7:0] MFPC_OFS_DOUT = 8'h3F;
   localparam logic [7:0] MFPC_OFS_IRQ = 8'h40;
   localparam logic [7:0] MFPC_OFS_BCLK2 = 8'h41;
   localparam logic [7:0] MFPC_RST_DOUT = 8'h10;
   localparam logic [7:0] MFPC_RST_IRQ = 8'h07;
   localparam logic [7:0] MFPC_RST_BCLK2 = 8'h00;
   localparam int MFPC_POS_LEVEL = 6;
   localparam int MFPC_NPINS = 3;

   typedef enum logic [4:0] {
      MFPC_FN_OFF = 5'h00,
      MFPC_FN_IN = 5'h01,
      MFPC_FN_LEVEL = 5'h03,
      MFPC_FN_BITBANG = 5'h04,
      MFPC_FN_PDMCLK = 5'h05,
      MFPC_FN_GENERAL_CLOCK_OUTPUT = 5'h06,
      MFPC_FN_INTERRUPT_LINE_ONE = 5'h07,
      MFPC_FN_INTERRUPT_LINE_TWO = 5'h08,
      MFPC_FN_INTERRUPT_LINE_THREE = 5'h09,
      MFPC_FN_INTERRUPT_LINE_FOUR = 5'h0A,
      MFPC_FN_P1WCLK = 5'h0C,
      MFPC_FN_P1BCLK = 5'h0D,
      MFPC_FN_P1DOUT = 5'h10,
      MFPC_FN_P1WCLK2 = 5'h11,
      MFPC_FN_P2BCLK = 5'h12,
      MFPC_FN_P2DOUT = 5'h15,
      MFPC_FN_AXWCLK = 5'h1B,
      MFPC_FN_AXBCLK = 5'h1C,
      MFPC_FN_AXDOUT = 5'h1D
   } mfpc_fn_e;

   // register layout: bit 7 spare, bit 6 static level, bit 5 spare, 4:0 function
   typedef struct packed {
      logic spare_hi;
      logic static_level;
      logic spare_lo;
      logic [4:0] function_select;
   } mfpc_cfg_s;

   // internal sources that a pin may carry
   typedef struct packed {
      logic shared_bitbang_level;
      logic pdm_clock;
      logic general_clock_output;
      logic [3:0] interrupt_line;
      logic port_one_word_clock_out;
      logic port_one_bit_clock_out;
      logic port_one_data_out;
      logic port_two_bit_clock_out;
      logic port_two_data_out;
      logic aux_port_word_clock_out;
      logic aux_port_bit_clock_out;
      logic aux_port_data_out;
   } mfpc_src_s;

   typedef struct packed {
      logic wr;
      logic [7:0] book;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mfpc_req_s;

   // per-pin drive: output value, output enable, input buffer enable
   typedef struct packed {
      logic out;
      logic oe;
      logic ie;
   } mfpc_drv_s;
endpackage
`default_nettype wire

//--- hdl/mfpc_top.sv
// mfpc_top: configuration registers and pin drive for three multifunction pins
// assumes the control-port decoder hands over one byte request per cycle on clk_sys
// Contract
// - selector 0 disables the pin and powers its buffers down
// - selector 1 makes the pin an input feeding the input multiplexer
// - selector 3 drives the pin with its static level bit 6
// - selector 4 drives the pin with the shared bit-bang level
// - selector 5 outputs the PDM clock
// - selector 6 outputs the general clock output
// - selectors 7 to 10 output interrupt lines one to four
// - selectors 12 and 13 output port one word and bit clocks
// - selector 16 outputs port one data, 17 its word clock
// - selector 18 outputs port two bit clock, 21 its data
// - selectors 27 to 29 output aux word clock, bit clock, data
// - data-out pin register at 0x3F book 0 page 1, resets to 10h
// - interrupt pin register at 0x40 book 0 page 1, resets to 7h
// - second bit-clock pin register at 0x41, resets to zero
`default_nettype none
module mfpc_top
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire mfpc_pkg::mfpc_req_s req,
   input wire logic req_valid,
   output mfpc_pkg::mfpc_cfg_s serial_dout_pin_config,
   output mfpc_pkg::mfpc_cfg_s irq_pin_config,
   output mfpc_pkg::mfpc_cfg_s second_bitclock_pin_config,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire mfpc_pkg::mfpc_src_s src,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic [2:0] pin_ie,
   output logic [2:0] pin_to_input_mux
);
   import mfpc_pkg::*;

   typedef struct packed {
      mfpc_cfg_s [MFPC_NPINS-1:0] cfg;
      logic [7:0] rdata;
      logic rvalid;
      mfpc_drv_s [MFPC_NPINS-1:0] drv;
      logic [2:0] in_s1;
      logic [2:0] in_s2;
      logic [2:0] in_s3;
      logic [2:0] in_q;
   } mfpc_state_s;

   localparam logic [7:0] OFS [MFPC_NPINS] = '{MFPC_OFS_DOUT, MFPC_OFS_IRQ, MFPC_OFS_BCLK2};
   localparam logic [7:0] RST [MFPC_NPINS] = '{MFPC_RST_DOUT, MFPC_RST_IRQ, MFPC_RST_BCLK2};

   mfpc_state_s st_q;
   mfpc_state_s st_d;
   mfpc_drv_s [MFPC_NPINS-1:0] mux_drv;
   logic page_hit;

   assign page_hit = req_valid && (req.book == MFPC_BOOK) && (req.page == MFPC_PAGE);

   genvar gi;
   generate
      for (gi = 0; gi < MFPC_NPINS; gi++)
      begin : g_pin
         mfpc_pin_mux u_mux
         (
            .cfg(st_q.cfg[gi]),
            .src(src),
            .drv(mux_drv[gi])
         );
         assign pin_out[gi] = st_q.drv[gi].out;
         assign pin_oe[gi] = st_q.drv[gi].oe;
         assign pin_ie[gi] = st_q.drv[gi].ie;
      end
   endgenerate

   always_comb
   begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      for (int i = 0; i < MFPC_NPINS; i++)
      begin
         if (page_hit && req.addr == OFS[i])
         begin
            if (req.wr)
               st_d.cfg[i] = req.wdata;
            else
               st_d.rdata = st_q.cfg[i];
         end
      end
      if (page_hit && !req.wr)
         st_d.rvalid = 1'b1;
      // unmapped reads answer zero
      if (page_hit && !req.wr && req.addr != OFS[0] && req.addr != OFS[1]
          && req.addr != OFS[2])
         st_d.rdata = 8'h00;
      st_d.drv = mux_drv;
      // pins are async to clk_sys; accept a change once stages two and three agree
      st_d.in_s1 = pin_in;
      st_d.in_s2 = st_q.in_s1;
      st_d.in_s3 = st_q.in_s2;
      for (int i = 0; i < MFPC_NPINS; i++)
      begin
         // a pin that stops listening must not leave a stale level at the input mux
         if (!st_q.drv[i].ie)
            st_d.in_q[i] = 1'b0;
         else if (st_q.in_s2[i] == st_q.in_s3[i])
            st_d.in_q[i] = st_q.in_s3[i];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         st_q <= '0;
         st_q.cfg[0] <= RST[0];
         st_q.cfg[1] <= RST[1];
         st_q.cfg[2] <= RST[2];
      end
      else
         st_q <= st_d;
   end

   assign serial_dout_pin_config = st_q.cfg[0];
   assign irq_pin_config = st_q.cfg[1];
   assign second_bitclock_pin_config = st_q.cfg[2];
   assign rdata = st_q.rdata;
   assign rvalid = st_q.rvalid;
   assign pin_to_input_mux = st_q.in_q;

   // a disabled pin neither drives nor listens, one cycle after its selector is seen
   a_off_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[2].function_select == 5'h00) |=> (!pin_oe[2] && !pin_ie[2]))
      else $error("disabled pin still has a buffer on");

   a_in_listens: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[0].function_select == 5'h01) |=> (pin_ie[0] && !pin_oe[0]))
      else $error("input pin not set to input");

   a_level_out: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[1].function_select == 5'h03) |=>
      (pin_oe[1] && pin_out[1] == $past(st_q.cfg[1].static_level)))
      else $error("static level not on pin");

   a_bitbang_out: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[0].function_select == 5'h04) |=>
      (pin_out[0] == $past(src.shared_bitbang_level)))
      else $error("bit-bang level not on pin");

   a_int_route: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[1].function_select == 5'h08) |=>
      (pin_oe[1] && pin_out[1] == $past(src.interrupt_line[1])))
      else $error("second interrupt line not routed");

   a_aux_data: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.cfg[2].function_select == 5'h1D) |=>
      (pin_out[2] == $past(src.aux_port_data_out)))
      else $error("aux data not on pin");

   a_write_store: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && req.wr && req.addr == 8'h40) |=> (irq_pin_config == $past(req.wdata)))
      else $error("write to interrupt pin register lost");

   sequence s_read_req;
      page_hit && !req.wr && req.addr == 8'h3F;
   endsequence
   a_read_back: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_read_req |=> (rvalid && rdata == $past(serial_dout_pin_config)))
      else $error("read of data-out register wrong");

   a_reset_vals: assert property (@(posedge clk_sys)
      $rose(resetn) |-> (irq_pin_config == 8'h07 && serial_dout_pin_config == 8'h10
      && second_bitclock_pin_config == 8'h00))
      else $error("reset values wrong");

   a_page_miss: assert property (@(posedge clk_sys) disable iff (!resetn)
      (req_valid && !page_hit) |=> (!rvalid && $stable(serial_dout_pin_config)
      && $stable(irq_pin_config) && $stable(second_bitclock_pin_config)))
      else $error("foreign request took effect");
   a_read_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && !req.wr) |=> rvalid)
      else $error("read not answered");
   a_no_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
      !(page_hit && !req.wr) |=> !rvalid)
      else $error("answer without a read");
   a_read_unmapped: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && !req.wr && req.addr != MFPC_OFS_DOUT && req.addr != MFPC_OFS_IRQ
      && req.addr != MFPC_OFS_BCLK2) |=> (rvalid && rdata == 8'h00))
      else $error("unmapped read not zero");
   a_read_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && !req.wr && req.addr == MFPC_OFS_IRQ) |=>
      (rvalid && rdata == $past(irq_pin_config)))
      else $error("read of interrupt pin register wrong");
   a_read_bclk2: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && !req.wr && req.addr == MFPC_OFS_BCLK2) |=>
      (rvalid && rdata == $past(second_bitclock_pin_config)))
      else $error("read of second bit-clock register wrong");
   a_write_dout: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && req.wr && req.addr == MFPC_OFS_DOUT) |=>
      (serial_dout_pin_config == $past(req.wdata)))
      else $error("write to data-out register lost");
   a_write_bclk2: assert property (@(posedge clk_sys) disable iff (!resetn)
      (page_hit && req.wr && req.addr == MFPC_OFS_BCLK2) |=>
      (second_bitclock_pin_config == $past(req.wdata)))
      else $error("write to second bit-clock register lost");
   a_reset_drive: assert property (@(posedge clk_sys)
      $rose(resetn) |=> (pin_oe == 3'b011 && pin_ie == 3'b000))
      else $error("pin drive after reset wrong");
   a_hold_cfg: assert property (@(posedge clk_sys) disable iff (!resetn)
      !(page_hit && req.wr) |=> ($stable(serial_dout_pin_config)
      && $stable(irq_pin_config) && $stable(second_bitclock_pin_config)))
      else $error("register changed without a write");

   // per-pin routing, one cycle behind the selector; reserved codes are software's to avoid
   generate
      for (gi = 0; gi < MFPC_NPINS; gi++)
      begin : g_chk
         a_pin_off: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_OFF) |=>
            (!pin_oe[gi] && !pin_ie[gi] && !pin_out[gi]))
            else $error("disabled pin active");
         a_pin_input: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_IN) |=>
            (pin_ie[gi] && !pin_oe[gi]))
            else $error("input pin not listening");
         a_pin_level: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_LEVEL) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(st_q.cfg[gi].static_level)))
            else $error("static level missing");
         a_pin_bitbang: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_BITBANG) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.shared_bitbang_level)))
            else $error("bit-bang level missing");
         a_pin_pdm: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_PDMCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.pdm_clock)))
            else $error("pdm clock missing");
         a_pin_general_clock_output: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_GENERAL_CLOCK_OUTPUT) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.general_clock_output)))
            else $error("clock output missing");
         a_int_one: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_INTERRUPT_LINE_ONE) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.interrupt_line[0])))
            else $error("interrupt one missing");
         a_int_two: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_INTERRUPT_LINE_TWO) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.interrupt_line[1])))
            else $error("interrupt two missing");
         a_int_three: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_INTERRUPT_LINE_THREE) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.interrupt_line[2])))
            else $error("interrupt three missing");
         a_int_four: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_INTERRUPT_LINE_FOUR) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.interrupt_line[3])))
            else $error("interrupt four missing");
         a_port1_word: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P1WCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_one_word_clock_out)))
            else $error("port one word clock missing");
         a_port1_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P1BCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_one_bit_clock_out)))
            else $error("port one bit clock missing");
         a_port1_data: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P1DOUT) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_one_data_out)))
            else $error("port one data missing");
         a_port1_word_alt: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P1WCLK2) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_one_word_clock_out)))
            else $error("port one word clock missing");
         a_port2_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P2BCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_two_bit_clock_out)))
            else $error("port two bit clock missing");
         a_port2_data: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_P2DOUT) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.port_two_data_out)))
            else $error("port two data missing");
         a_auxport_word: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_AXWCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.aux_port_word_clock_out)))
            else $error("aux word clock missing");
         a_auxport_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_AXBCLK) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.aux_port_bit_clock_out)))
            else $error("aux bit clock missing");
         a_auxport_data: assert property (@(posedge clk_sys) disable iff (!resetn)
            (st_q.cfg[gi].function_select == MFPC_FN_AXDOUT) |=>
            (pin_oe[gi] && !pin_ie[gi] && pin_out[gi] == $past(src.aux_port_data_out)))
            else $error("aux data missing");
         a_in_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
            !pin_ie[gi] |=> !pin_to_input_mux[gi])
            else $error("input mux fed by a pin that is not listening");
         a_in_settle: assert property (@(posedge clk_sys) disable iff (!resetn)
            (pin_ie[gi] && st_q.in_s2[gi] != st_q.in_s3[gi]) |=>
            $stable(pin_to_input_mux[gi]))
            else $error("unsettled pin level passed on");
         a_in_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
            (pin_ie[gi] && st_q.in_s2[gi] == st_q.in_s3[gi]) |=>
            (pin_to_input_mux[gi] == $past(st_q.in_s3[gi])))
            else $error("settled pin level not passed on");
      end
   endgenerate
endmodule
`default_nettype wire
